// ### hdl/ppms_pkg.sv
// Types shared by the profile position move sequencer
package ppms_pkg;

  typedef struct packed {
    logic [31:0] target;
    logic [31:0] vel;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] jerk;
    logic [15:0] shape;
  } ppms_move_t;

  typedef enum logic [1:0] {
    PPMS_IDLE,
    PPMS_RUN,
    PPMS_HALTED
  } ppms_state_t;

endpackage

// ### hdl/ppms_regs.svh
// Object indices, field positions, codes and timing counts of the move sequencer
`ifndef PPMS_REGS_SVH
`define PPMS_REGS_SVH

`define PPMS_IDX_JERK       16'h2121
`define PPMS_IDX_MODE       16'h6060
`define PPMS_IDX_TARGET     16'h607a
`define PPMS_IDX_VEL        16'h6081
`define PPMS_IDX_ACC        16'h6083
`define PPMS_IDX_DEC        16'h6084
`define PPMS_IDX_ABORT      16'h6085
`define PPMS_IDX_SHAPE      16'h6086

`define PPMS_MODE_PROF_POS  8'h01
`define PPMS_SHAPE_TRAP     16'h0000
`define PPMS_SHAPE_SCURVE   16'h0003
`define PPMS_SHAPE_SPECVEL  16'hffff

`define PPMS_CW_NEW_SP      4
`define PPMS_CW_CHG_IMM     5
`define PPMS_CW_RELATIVE    6
`define PPMS_CW_HALT        8
`define PPMS_CW_CHG_SP      9
`define PPMS_SW_REACHED     10
`define PPMS_SW_SP_ACK      12

`define PPMS_RST_WORD       32'h0000_0000
`define PPMS_RST_MODE       8'h00
`define PPMS_RST_SHAPE      16'h0000

`define PPMS_CLK_NS         20
`define PPMS_CTRL_CYCLE_NS  10000
`define PPMS_CTRL_CYCLES    (`PPMS_CTRL_CYCLE_NS / `PPMS_CLK_NS)

`endif

// ### hdl/ppms_sequencer.sv
// Profile position move sequencer: move buffer, control word handshake, point-to-point trajectory
`timescale 1ns/100ps
`default_nettype none
`include "ppms_regs.svh"

// What this block does
// - Moves run only while operating mode select holds profile position.
// - Offers trapezoidal profile and jerk-bounded S-curve profile.
// - S-curve uses ramp-up rate for both speed-up and slow-down.
// - In-progress moves may change for trapezoid and special velocity, never S-curve.
// - Profile shape select chooses trapezoid, S-curve or special velocity.
// - Special velocity honours rates and cruise but never arrives.
// - Special velocity uses the target only for direction.
// - Relative destination is target plus the commanded position.
// - Absolute destination is the target taken from home.
// - Discrete moves with control bit 5 clear slow to zero before the next one starts.
// - Continuous series of moves only with the trapezoidal profile.
// - Continuous moves do not stop; next parameters apply at previous end.
// - Trapezoid holds one extra set-point, started when current move ends.
// - Jerk limit bounds acceleration change, used only in S-curve.
// - Destination comes from the move target object.
// - Cruise speed comes from the cruise velocity object.
// - Acceleration comes from the ramp-up rate object.
// - Abort ramp-down rate is unbuffered and applies at once.
// - Next-move parameters live in a buffer apart from the active ones.
// - Buffer may be rewritten any time before it is copied.
// - Rising control bit 4 copies the buffer to active and starts.
// - With control bit 5 clear, bit 4 edges during a move are ignored.
// - Status bit 10 sets on arrival or halt, clears on new target.
// - Status bit 12 sets on valid bit 4 edge, clears with bit 4.
module ppms_sequencer (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  // Object access
  input  wire logic                   obj_wr_i,
  input  wire logic                   obj_rd_i,
  input  wire logic [15:0]            obj_index_i,
  input  wire logic [31:0]            obj_wdata_i,
  output var  logic [31:0]            obj_rdata_o,
  output var  logic                   obj_rvalid_o,
  // Control and status words
  input  wire logic [15:0]            ctrl_word_i,
  input  wire logic                   quick_stop_i,
  output var  logic [15:0]            status_word_o,
  // Trajectory
  output var  logic [31:0]            cmd_pos_o,
  output var  logic [31:0]            cmd_vel_o,
  output var  ppms_pkg::ppms_move_t   active_move_o
);
  import ppms_pkg::*;

  localparam int unsigned TICK_MAX = `PPMS_CTRL_CYCLES - 1;

  ppms_move_t  buf_move;
  ppms_move_t  pend_move;
  logic        pend_rel;
  logic        pend_valid;
  logic [7:0]  op_mode;
  logic [31:0] abort_rate;
  logic [31:0] dest;
  logic [31:0] brake_dist;
  logic [31:0] ramp;
  logic        slow_q;
  logic        nsp_q;
  logic [15:0] tick_cnt;
  logic        tick;
  ppms_state_t state;

  // Decoded control
  logic        nsp_rise;
  logic        pp_mode;
  logic        moving;
  logic        halt;
  logic        act_scurve;
  logic        act_spec;
  logic        valid_edge;
  logic        take_now;
  logic        queue_it;

  always_comb begin
    // The master drives the control word on this clock, so one flop of history finds the edge
    nsp_rise   = ctrl_word_i[`PPMS_CW_NEW_SP] & ~nsp_q;
    pp_mode    = (op_mode == `PPMS_MODE_PROF_POS);
    moving     = (state != PPMS_IDLE);
    halt       = ctrl_word_i[`PPMS_CW_HALT];
    act_scurve = (active_move_o.shape == `PPMS_SHAPE_SCURVE);
    act_spec   = (active_move_o.shape == `PPMS_SHAPE_SPECVEL);
    // Edge during a move needs bit 5 and a shape that can be changed
    valid_edge = nsp_rise & pp_mode & ~quick_stop_i &
                 (~moving | (ctrl_word_i[`PPMS_CW_CHG_IMM] & ~act_scurve));
    // Bit 9 with a trapezoid parks the set-point until the current move ends
    queue_it   = valid_edge & moving & ctrl_word_i[`PPMS_CW_CHG_SP] &
                 (active_move_o.shape == `PPMS_SHAPE_TRAP);
    take_now   = valid_edge & ~queue_it;
  end

  // Control cycle divider
  // Restarts at reset, so the first step lands a full control cycle after release
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_MAX[15:0]) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // Object writes: move objects go to the buffer, abort rate is live
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      buf_move   <= '0;
      op_mode    <= `PPMS_RST_MODE;
      abort_rate <= `PPMS_RST_WORD;
    end else if (obj_wr_i) begin
      if (obj_index_i == `PPMS_IDX_JERK) begin
        buf_move.jerk <= obj_wdata_i;
      end else if (obj_index_i == `PPMS_IDX_MODE) begin
        op_mode <= obj_wdata_i[7:0];
      end else if (obj_index_i == `PPMS_IDX_TARGET) begin
        buf_move.target <= obj_wdata_i;
      end else if (obj_index_i == `PPMS_IDX_VEL) begin
        buf_move.vel <= obj_wdata_i;
      end else if (obj_index_i == `PPMS_IDX_ACC) begin
        buf_move.acc <= obj_wdata_i;
      end else if (obj_index_i == `PPMS_IDX_DEC) begin
        buf_move.dec <= obj_wdata_i;
      end else if (obj_index_i == `PPMS_IDX_ABORT) begin
        abort_rate <= obj_wdata_i;
      end else if (obj_index_i == `PPMS_IDX_SHAPE) begin
        buf_move.shape <= obj_wdata_i[15:0];
      end
    end
  end

  // Object reads: one cycle latency, unknown indices read zero
  // Reads show the buffer, not the running move, so a master can check the next move first
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      obj_rdata_o  <= 32'h0000_0000;
      obj_rvalid_o <= 1'b0;
    end else begin
      obj_rvalid_o <= obj_rd_i;
      if (!obj_rd_i) begin
        obj_rdata_o <= obj_rdata_o;
      end else if (obj_index_i == `PPMS_IDX_JERK) begin
        obj_rdata_o <= buf_move.jerk;
      end else if (obj_index_i == `PPMS_IDX_MODE) begin
        obj_rdata_o <= {24'h000000, op_mode};
      end else if (obj_index_i == `PPMS_IDX_TARGET) begin
        obj_rdata_o <= buf_move.target;
      end else if (obj_index_i == `PPMS_IDX_VEL) begin
        obj_rdata_o <= buf_move.vel;
      end else if (obj_index_i == `PPMS_IDX_ACC) begin
        obj_rdata_o <= buf_move.acc;
      end else if (obj_index_i == `PPMS_IDX_DEC) begin
        obj_rdata_o <= buf_move.dec;
      end else if (obj_index_i == `PPMS_IDX_ABORT) begin
        obj_rdata_o <= abort_rate;
      end else if (obj_index_i == `PPMS_IDX_SHAPE) begin
        obj_rdata_o <= {16'h0000, buf_move.shape};
      end else begin
        obj_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // Trajectory step for one control cycle
  logic [32:0] rem;
  logic [32:0] rem_mag;
  logic        dir_pos;
  logic        slow;
  logic [32:0] ramp_sum;
  logic [31:0] next_ramp;
  logic [31:0] rate_up;
  logic [31:0] rate_dn;
  logic [32:0] up_sum;
  logic [31:0] next_vel;
  logic [31:0] step;
  logic        arrive;
  logic [31:0] next_pos;

  always_comb begin
    rem     = {dest[31], dest} - {cmd_pos_o[31], cmd_pos_o};
    rem_mag = rem[32] ? (33'h0 - rem) : rem;
    // Special velocity heads toward the sign of the target forever
    dir_pos = act_spec ? ~active_move_o.target[31] : ~rem[32];
    // A parked set-point suppresses braking so the motor runs straight into the next move
    slow    = halt | quick_stop_i | ~pp_mode |
              (~act_spec & ~pend_valid & (rem_mag <= {1'b0, brake_dist}));
    // Jerk-limited ramp of the rate; restarts when the phase flips
    ramp_sum  = {1'b0, (slow == slow_q) ? ramp : 32'h0000_0000} + {1'b0, active_move_o.jerk};
    next_ramp = (ramp_sum > {1'b0, active_move_o.acc}) ? active_move_o.acc : ramp_sum[31:0];
    rate_up   = act_scurve ? next_ramp : active_move_o.acc;
    if (quick_stop_i) begin
      rate_dn = abort_rate;
    end else if (act_scurve) begin
      rate_dn = next_ramp;
    end else begin
      rate_dn = active_move_o.dec;
    end
    up_sum = {1'b0, cmd_vel_o} + {1'b0, rate_up};
    if (slow || cmd_vel_o > active_move_o.vel) begin
      next_vel = (cmd_vel_o > rate_dn) ? (cmd_vel_o - rate_dn) : 32'h0000_0000;
      if (!slow && next_vel < active_move_o.vel) begin
        next_vel = active_move_o.vel;
      end
    end else if (up_sum > {1'b0, active_move_o.vel}) begin
      next_vel = active_move_o.vel;
    end else begin
      next_vel = up_sum[31:0];
    end
    // Creep so a short brake estimate cannot stall short of the target
    if (!halt && !quick_stop_i && pp_mode && !act_spec && rem_mag != 33'h0 && next_vel == 32'h0) begin
      next_vel = 32'h0000_0001;
    end
    if (!act_spec && {1'b0, next_vel} >= rem_mag) begin
      step   = rem_mag[31:0];
      arrive = 1'b1;
    end else begin
      step   = next_vel;
      arrive = 1'b0;
    end
    next_pos = dir_pos ? (cmd_pos_o + step) : (cmd_pos_o - step);
  end

  // Activation of a move from the buffer or the parked set-point
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      active_move_o <= '0;
      dest          <= `PPMS_RST_WORD;
      pend_move     <= '0;
      pend_rel      <= 1'b0;
      pend_valid    <= 1'b0;
    end else if (take_now) begin
      active_move_o <= buf_move;
      // Relative base is the position at the accepted edge, not at the first tick
      if (ctrl_word_i[`PPMS_CW_RELATIVE]) begin
        dest <= buf_move.target + cmd_pos_o;
      end else begin
        dest <= buf_move.target;
      end
    end else if (queue_it) begin
      pend_move  <= buf_move;
      pend_rel   <= ctrl_word_i[`PPMS_CW_RELATIVE];
      pend_valid <= 1'b1;
    end else if (tick && state == PPMS_RUN && arrive && pend_valid) begin
      active_move_o <= pend_move;
      // A parked relative move counts from the end of the move it follows
      dest          <= pend_rel ? (pend_move.target + next_pos) : pend_move.target;
      pend_valid    <= 1'b0;
    end else if (quick_stop_i || !pp_mode) begin
      // An abandoned move drops any parked set-point
      pend_valid <= 1'b0;
    end
  end

  // Commanded position and velocity, once per control cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cmd_pos_o  <= `PPMS_RST_WORD;
      cmd_vel_o  <= `PPMS_RST_WORD;
      brake_dist <= `PPMS_RST_WORD;
      ramp       <= `PPMS_RST_WORD;
      slow_q     <= 1'b0;
    end else if (tick && state == PPMS_RUN) begin
      cmd_pos_o <= next_pos;
      ramp      <= next_ramp;
      slow_q    <= slow;
      // Brake distance mirrors the distance spent speeding up
      if (arrive && !pend_valid) begin
        cmd_vel_o  <= 32'h0000_0000;
        brake_dist <= 32'h0000_0000;
      end else begin
        cmd_vel_o <= next_vel;
        if (next_vel > cmd_vel_o) begin
          brake_dist <= brake_dist + step;
        end else if (next_vel < cmd_vel_o) begin
          brake_dist <= (brake_dist > step) ? (brake_dist - step) : 32'h0000_0000;
        end
      end
    // Outside a move the profile state clears so the next move starts from rest
    end else if (state == PPMS_IDLE) begin
      cmd_vel_o  <= 32'h0000_0000;
      brake_dist <= 32'h0000_0000;
      ramp       <= 32'h0000_0000;
    end
  end

  // Move state
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state <= PPMS_IDLE;
    end else begin
      case (state)
        PPMS_IDLE: begin
          if (take_now) begin
            state <= PPMS_RUN;
          end
        end
        PPMS_RUN: begin
          // A set-point taken on the arrival tick must not be lost to the idle transition
          if (valid_edge) begin
            state <= PPMS_RUN;
          end else if (tick) begin
            if (arrive && !pend_valid) begin
              state <= PPMS_IDLE;
            end else if (next_vel == 32'h0000_0000 && (quick_stop_i || !pp_mode)) begin
              state <= PPMS_IDLE;
            end else if (next_vel == 32'h0000_0000 && halt) begin
              state <= PPMS_HALTED;
            end
          end
        end
        PPMS_HALTED: begin
          // Release resumes the same move; quick stop or leaving the mode abandons it
          if (quick_stop_i || !pp_mode) begin
            state <= PPMS_IDLE;
          end else if (!halt || take_now) begin
            state <= PPMS_RUN;
          end
        end
        default: begin
          state <= PPMS_IDLE;
        end
      endcase
    end
  end

  // Handshake flags
  logic next_reached;
  logic next_ack;

  always_comb begin
    next_reached = status_word_o[`PPMS_SW_REACHED];
    // A parked set-point is a new target too; it outranks a same-cycle arrival
    if (valid_edge) begin
      next_reached = 1'b0;
    end else if (tick && state == PPMS_RUN && next_vel == 32'h0000_0000 &&
                 (halt || quick_stop_i || !pp_mode)) begin
      next_reached = 1'b1;
    end else if (tick && state == PPMS_RUN && arrive && !pend_valid) begin
      next_reached = 1'b1;
    end
    // Set wins: a valid edge implies bit 4 is high in the same cycle
    next_ack = status_word_o[`PPMS_SW_SP_ACK] & ctrl_word_i[`PPMS_CW_NEW_SP];
    if (valid_edge) begin
      next_ack = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      nsp_q         <= 1'b0;
      // Only bits 10 and 12 are ever driven; the rest of the word stays zero
      status_word_o <= 16'h0000;
    end else begin
      nsp_q                            <= ctrl_word_i[`PPMS_CW_NEW_SP];
      status_word_o[`PPMS_SW_REACHED]  <= next_reached;
      status_word_o[`PPMS_SW_SP_ACK]   <= next_ack;
    end
  end

endmodule
`default_nettype wire

// ### verification/ppms_master_model.sv
// Network master model that writes move objects and drives the control word
`timescale 1ns/100ps
`default_nettype none
module ppms_master_model (
  // Clock
  input  wire logic        core_clk_i,
  // Object access
  input  wire logic [31:0] obj_rdata_i,
  input  wire logic        obj_rvalid_i,
  output var  logic        obj_wr_o,
  output var  logic        obj_rd_o,
  output var  logic [15:0] obj_index_o,
  output var  logic [31:0] obj_wdata_o,
  // Control word
  output var  logic [15:0] ctrl_word_o,
  output var  logic        quick_stop_o
);
  initial begin
    obj_wr_o = 1'b0;
    obj_rd_o = 1'b0;
    obj_index_o = 16'h0;
    obj_wdata_o = 32'h0;
    ctrl_word_o = 16'h0;
    quick_stop_o = 1'b0;
  end

  // Released lines show inverted data so stale values never look valid
  task automatic write_obj(input logic [15:0] idx, input logic [31:0] d);
    @(posedge core_clk_i);
    obj_wr_o <= 1'b1;
    obj_index_o <= idx;
    obj_wdata_o <= d;
    @(posedge core_clk_i);
    obj_wr_o <= 1'b0;
    obj_index_o <= ~idx;
    obj_wdata_o <= ~d;
  endtask

  task automatic read_obj(input logic [15:0] idx, output logic [31:0] q, output logic ok);
    @(posedge core_clk_i);
    obj_rd_o <= 1'b1;
    obj_index_o <= idx;
    @(posedge core_clk_i);
    obj_rd_o <= 1'b0;
    obj_index_o <= ~idx;
    #1;
    q = obj_rdata_i;
    ok = obj_rvalid_i;
  endtask

  // A new move is asked for by raising bit 4; bit 9 picks parking
  task automatic set_ctrl(input logic [15:0] w);
    @(posedge core_clk_i);
    ctrl_word_o <= w;
  endtask

  // Quick stop is a level held for as long as the abort lasts
  task automatic set_quick_stop(input logic q);
    @(posedge core_clk_i);
    quick_stop_o <= q;
  endtask
endmodule
`default_nettype wire

// ### verification/ppms_sequencer_assertions.sv
// Port-level assertions of the profile position move sequencer
`timescale 1ns/100ps
`default_nettype none
module ppms_sequencer_assertions (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        obj_rd_i,
  input wire logic [31:0] obj_rdata_o,
  input wire logic        obj_rvalid_o,
  input wire logic [15:0] ctrl_word_i,
  input wire logic [15:0] status_word_o,
  input wire logic [31:0] cmd_pos_o,
  input wire logic [31:0] cmd_vel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_read_answered: assert property (obj_rd_i |=> obj_rvalid_o)
    else $error("read not answered next cycle");
  a_rvalid_single: assert property (!obj_rd_i |=> !obj_rvalid_o)
    else $error("read answer without a read");
  a_rdata_holds: assert property (!obj_rvalid_o |-> $stable(obj_rdata_o))
    else $error("read data moved between answers");
  a_ack_on_edge: assert property ($rose(status_word_o[12]) |-> $past(ctrl_word_i[4]) && !$past(ctrl_word_i[4], 2))
    else $error("acknowledge without a rising new set-point bit");
  a_ack_clears: assert property (!ctrl_word_i[4] |=> !status_word_o[12])
    else $error("acknowledge kept after bit 4 fell");
  a_ack_holds: assert property (status_word_o[12] && ctrl_word_i[4] |=> status_word_o[12])
    else $error("acknowledge dropped while bit 4 high");
  a_reached_new_target: assert property ($rose(status_word_o[12]) |-> !status_word_o[10])
    else $error("target reached kept on new target");
  a_reached_at_rest: assert property ($rose(status_word_o[10]) |-> cmd_vel_o == 32'h0)
    else $error("target reached while still moving");
  // Control ticks are hundreds of clocks apart, so eight quiet cycles is a safe floor
  a_pos_per_tick: assert property (!$stable(cmd_pos_o) |=> $stable(cmd_pos_o) [*8])
    else $error("commanded position stepped twice within a control cycle");
endmodule

bind ppms_sequencer ppms_sequencer_assertions ppms_sequencer_assertions_i (
  .core_clk_i   (core_clk_i),
  .rst_b_i      (rst_b_i),
  .obj_rd_i     (obj_rd_i),
  .obj_rdata_o  (obj_rdata_o),
  .obj_rvalid_o (obj_rvalid_o),
  .ctrl_word_i  (ctrl_word_i),
  .status_word_o(status_word_o),
  .cmd_pos_o    (cmd_pos_o),
  .cmd_vel_o    (cmd_vel_o)
);
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the profile position move sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ppms_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import ppms_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        obj_wr, obj_rd, obj_rvalid, quick_stop, ok;
  logic [15:0] obj_index, ctrl_word, status_word;
  logic [31:0] obj_wdata, obj_rdata, cmd_pos, cmd_vel, rd_q, pos0, tgt;
  ppms_move_t  active_move;
  int          n_fail = 0;
  int          check_count = 0;
  integer      seed = 66262;
  logic [15:0] idx_tab [9] = '{`PPMS_IDX_JERK, `PPMS_IDX_MODE, `PPMS_IDX_TARGET, `PPMS_IDX_VEL,
                               `PPMS_IDX_ACC, `PPMS_IDX_DEC, `PPMS_IDX_ABORT, `PPMS_IDX_SHAPE, 16'h1234};

  always #10 core_clk = ~core_clk;

  ppms_master_model ppms_master_model_i (
    .core_clk_i(core_clk), .obj_rdata_i(obj_rdata), .obj_rvalid_i(obj_rvalid), .obj_wr_o(obj_wr),
    .obj_rd_o(obj_rd), .obj_index_o(obj_index), .obj_wdata_o(obj_wdata), .ctrl_word_o(ctrl_word),
    .quick_stop_o(quick_stop));
  ppms_sequencer ppms_sequencer_i (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .obj_wr_i(obj_wr), .obj_rd_i(obj_rd),
    .obj_index_i(obj_index), .obj_wdata_i(obj_wdata), .obj_rdata_o(obj_rdata), .obj_rvalid_o(obj_rvalid),
    .ctrl_word_i(ctrl_word), .quick_stop_i(quick_stop), .status_word_o(status_word),
    .cmd_pos_o(cmd_pos), .cmd_vel_o(cmd_vel), .active_move_o(active_move));

  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Moves take a few control cycles; the bound covers the slowest scenario many times over
  task automatic wait_reached();
    int k;
    k = 0;
    while (status_word[10] !== 1'b1 && k < 40000) begin
      tick(1);
      k++;
    end
    if (k == 40000) begin
      n_fail++;
      end_sim();
    end
  endtask

  function automatic logic [31:0] obj_mask(input logic [15:0] idx);
    case (idx)
      `PPMS_IDX_MODE:  return 32'h0000_00ff;
      `PPMS_IDX_SHAPE: return 32'h0000_ffff;
      default:         return 32'hffff_ffff;
    endcase
  endfunction

  function automatic logic [31:0] dest(input logic rel, input logic [31:0] base, input logic [31:0] t);
    return rel ? base + t : t;
  endfunction

  task automatic setmove(input logic [15:0] shape, input logic [31:0] t, input logic [31:0] v);
    ppms_master_model_i.write_obj(`PPMS_IDX_SHAPE, {16'h0, shape});
    ppms_master_model_i.write_obj(`PPMS_IDX_TARGET, t);
    ppms_master_model_i.write_obj(`PPMS_IDX_VEL, v);
    ppms_master_model_i.write_obj(`PPMS_IDX_ACC, 32'h64);
    ppms_master_model_i.write_obj(`PPMS_IDX_DEC, 32'h64);
    ppms_master_model_i.write_obj(`PPMS_IDX_JERK, 32'h64);
  endtask

  task automatic ctl(input logic [15:0] w);
    ppms_master_model_i.set_ctrl(w);
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      ppms_master_model_i.read_obj(idx_tab[i], rd_q, ok);
      `CHK("rvalid", 1'b1, ok)
      `CHK("reset value", 32'h0, rd_q)
    end
    // Second write overwrites the first before any copy
    for (int i = 0; i < 8; i++) begin
      tgt = $random(seed);
      ppms_master_model_i.write_obj(idx_tab[i], $random(seed));
      ppms_master_model_i.write_obj(idx_tab[i], tgt);
      ppms_master_model_i.read_obj(idx_tab[i], rd_q, ok);
      `CHK("readback", tgt & obj_mask(idx_tab[i]), rd_q)
    end
    ppms_master_model_i.write_obj(`PPMS_IDX_MODE, 32'h0);
    setmove(`PPMS_SHAPE_TRAP, 32'd20, 32'd8);
    ctl(16'h0010);
    tick(1);
    `CHK("ack outside mode", 1'b0, status_word[12])
    ctl(16'h0000);
    ppms_master_model_i.write_obj(`PPMS_IDX_MODE, {24'h0, `PPMS_MODE_PROF_POS});
    ctl(16'h0010);
    tick(1);
    `CHK("ack", 1'b1, status_word[12])
    `CHK("reached cleared", 1'b0, status_word[10])
    `CHK("active target", 32'd20, active_move.target)
    ctl(16'h0000);
    ctl(16'h0010);
    tick(1);
    `CHK("ack while moving", 1'b0, status_word[12])
    wait_reached();
    `CHK("absolute end", dest(1'b0, 32'h0, 32'd20), cmd_pos)
    ctl(16'h0000);
    tgt = ($random(seed) & 32'hf) + 32'h1;
    setmove(`PPMS_SHAPE_TRAP, tgt, 32'd8);
    pos0 = cmd_pos;
    ctl(16'h0050);
    tick(1);
    wait_reached();
    `CHK("relative end", dest(1'b1, pos0, tgt), cmd_pos)
    ctl(16'h0000);
    setmove(`PPMS_SHAPE_SCURVE, 32'd60, 32'd4);
    ctl(16'h0030);
    tick(1);
    `CHK("s-curve ack", 1'b1, status_word[12])
    ppms_master_model_i.write_obj(`PPMS_IDX_TARGET, 32'h0);
    ctl(16'h0020);
    ctl(16'h0030);
    tick(1);
    `CHK("s-curve change ack", 1'b0, status_word[12])
    `CHK("s-curve target kept", 32'd60, active_move.target)
    wait_reached();
    `CHK("s-curve end", 32'd60, cmd_pos)
    ctl(16'h0020);
    setmove(`PPMS_SHAPE_TRAP, 32'd100, 32'd8);
    ctl(16'h0030);
    ppms_master_model_i.write_obj(`PPMS_IDX_TARGET, 32'd70);
    ctl(16'h0020);
    ctl(16'h0030);
    tick(1);
    `CHK("replace ack", 1'b1, status_word[12])
    `CHK("replaced target", 32'd70, active_move.target)
    wait_reached();
    `CHK("replaced end", 32'd70, cmd_pos)
    // Bit 9 parks the second set-point; the series must not stop at 90
    ctl(16'h0020);
    setmove(`PPMS_SHAPE_TRAP, 32'd90, 32'd8);
    ctl(16'h0030);
    ppms_master_model_i.write_obj(`PPMS_IDX_TARGET, 32'd110);
    ctl(16'h0220);
    ctl(16'h0230);
    tick(1);
    `CHK("parked ack", 1'b1, status_word[12])
    `CHK("parked keeps active", 32'd90, active_move.target)
    wait_reached();
    `CHK("continuous end", 32'd110, cmd_pos)
    ctl(16'h0000);
    // A target behind the position tells direction-only use from a destination
    setmove(`PPMS_SHAPE_SPECVEL, 32'd10, 32'd8);
    pos0 = cmd_pos;
    ctl(16'h0010);
    tick(5 * `PPMS_CTRL_CYCLES);
    `CHK("never arrives", 1'b0, status_word[10])
    `CHK("direction", 1'b1, $signed(cmd_pos) > $signed(pos0))
    ppms_master_model_i.write_obj(`PPMS_IDX_ABORT, 32'd1);
    ppms_master_model_i.set_quick_stop(1'b1);
    tick(`PPMS_CTRL_CYCLES);
    `CHK("abort rate live", 32'd7, cmd_vel)
    ppms_master_model_i.write_obj(`PPMS_IDX_ABORT, 32'd100);
    wait_reached();
    `CHK("abort stop speed", 32'h0, cmd_vel)
    ppms_master_model_i.set_quick_stop(1'b0);
    ctl(16'h0000);
    ctl(16'h0010);
    tick(2 * `PPMS_CTRL_CYCLES);
    ctl(16'h0110);
    wait_reached();
    `CHK("halt speed", 32'h0, cmd_vel)
    end_sim();
  end
endmodule
`default_nettype wire
